// File: logic/pp_setpoint_map.vh
`ifndef PP_SETPOINT_MAP_VH
`define PP_SETPOINT_MAP_VH

// Object dictionary indices
`define OD_FAULT_CODE 16'h603F
`define OD_COMMAND_WORD 16'h6040
`define OD_STATE_WORD 16'h6041
`define OD_OP_SELECT 16'h6060
`define OD_OP_IN_EFFECT 16'h6061
`define OD_POS_DEMAND 16'h6062
`define OD_POS_ENCODER 16'h6063
`define OD_POS_USER 16'h6064
`define OD_VEL_ACTUAL 16'h606C
`define OD_GOAL_POS 16'h607A
`define OD_MOVE_VEL 16'h6081
`define OD_MOVE_ACCEL 16'h6083
`define OD_MOVE_DECEL 16'h6084

// Command word bit positions
`define CW_SWITCH_ON 0
`define CW_VOLTAGE 1
`define CW_QUICK_STOP_N 2
`define CW_OPERATION 3
`define CW_NEW_SETPOINT 4
`define CW_IMMEDIATE 5
`define CW_RELATIVE 6

// State word bit positions
`define SW_READY 0
`define SW_SWITCHED_ON 1
`define SW_OP_ENABLED 2
`define SW_FAULT 3
`define SW_VOLTAGE 4
`define SW_QUICK_STOP_N 5
`define SW_ON_DISABLED 6
`define SW_REMOTE 9
`define SW_TARGET_REACHED 10
`define SW_SETPOINT_ACK 12
`define SW_FOLLOW_ERR 13
`define SW_HOME_FOUND 15

// Mode code of profile position operation
`define MODE_PROFILE_POS 8'h01

// Reset values
`define RST_COMMAND_WORD 16'h0000
`define RST_OP_SELECT 8'h00
`define RST_WORD32 32'h0000_0000

`endif

// File: logic/segment_runner.v
`timescale 1ns/100ps

// Simplified ramp: speed is in position units per clock tick, rates per tick.
// A replan keeps the present speed, so motion continues without a stop.
module segment_runner (
    input wire clk,
    input wire srst,
    input wire ce,
    input wire load,
    input wire [31:0] load_end,
    input wire halt,
    input wire [31:0] max_speed,
    input wire [31:0] accel,
    input wire [31:0] decel,
    output reg [31:0] pos_q,
    output reg [31:0] end_q,
    output reg [31:0] speed_q,
    output reg busy_q,
    output reg done_q
);

    reg [32:0] rem;
    reg [32:0] mag;
    reg [32:0] up;
    reg [31:0] spd_d;
    reg [32:0] step;

    always @* begin
        rem = {pos_q[31], pos_q};
        rem = {end_q[31], end_q} - rem;
        mag = rem[32] ? (33'h0_0000_0000 - rem) : rem;
        up = {1'b0, speed_q} + {1'b0, accel};
        if (mag <= {1'b0, speed_q}) begin
            spd_d = (speed_q > decel) ? (speed_q - decel) : 32'h0000_0000;
        end else if (up > {1'b0, max_speed}) begin
            spd_d = max_speed;
        end else begin
            spd_d = up[31:0];
        end
        // Creep at one unit so a zero speed setting cannot stall a segment
        step = (spd_d == 32'h0000_0000) ? 33'h0_0000_0001 : {1'b0, spd_d};
        if (step > mag) begin
            step = mag;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            pos_q <= 32'h0000_0000;
            end_q <= 32'h0000_0000;
            speed_q <= 32'h0000_0000;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else if (ce) begin
            done_q <= 1'b0;
            if (halt) begin
                end_q <= pos_q;
                speed_q <= 32'h0000_0000;
                busy_q <= 1'b0;
            end else if (load) begin
                end_q <= load_end;
                busy_q <= 1'b1;
            end else if (busy_q) begin
                speed_q <= spd_d;
                if (rem[32]) begin
                    pos_q <= pos_q - step[31:0];
                end else begin
                    pos_q <= pos_q + step[31:0];
                end
                if (step == mag) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                    speed_q <= 32'h0000_0000;
                end
            end
        end
    end

endmodule // segment_runner

// File: logic/profile_position_setpoint_handler.v
`timescale 1ns/100ps
`include "pp_setpoint_map.vh"

module profile_position_setpoint_handler (
    input wire clk,
    input wire srst,
    input wire ce,
    input wire [15:0] od_index,
    input wire od_wr,
    input wire od_rd,
    input wire [31:0] od_wdata,
    output reg [31:0] od_rdata,
    output reg od_ack,
    output reg od_err,
    input wire [15:0] fault_code_in,
    input wire fault_active,
    input wire following_error,
    input wire home_done,
    input wire [31:0] enc_position,
    input wire [31:0] user_position,
    input wire [31:0] actual_velocity,
    output wire [31:0] demand_position,
    output wire [31:0] demand_speed,
    output wire motion_busy,
    output wire drive_enabled
);

    // ********************************
    // Power state machine
    // ********************************
    localparam [3:0] ST_DISABLED = 4'b0001;
    localparam [3:0] ST_READY = 4'b0010;
    localparam [3:0] ST_SWITCHED_ON = 4'b0100;
    localparam [3:0] ST_ENABLED = 4'b1000;

    reg [3:0] state_q;
    reg [3:0] state_d;

    // ********************************
    // Object dictionary storage
    // ********************************
    reg [15:0] command_word_q;
    reg [7:0] operation_select_q;
    reg [31:0] goal_position_q;
    reg [31:0] move_velocity_q;
    reg [31:0] move_accel_q;
    reg [31:0] move_decel_q;

    // ********************************
    // Set-point bookkeeping
    // ********************************
    reg trigger_prev_q;
    reg reached_q;
    reg ack_q;
    reg pend_q;
    reg pend_rel_q;
    reg [31:0] pend_goal_q;

    wire [31:0] run_pos;
    wire [31:0] run_end;
    wire [31:0] run_speed;
    wire run_busy;
    wire run_done;

    wire op_enabled;
    wire pp_selected;
    wire trigger_edge;
    wire accept;
    wire start_pend;
    wire busy_eff;
    wire accept_now;
    wire halt;
    wire [15:0] state_word;

    reg load;
    reg [31:0] load_end;
    reg [32:0] rel_sum;

    assign op_enabled = (state_q == ST_ENABLED);
    assign pp_selected = (operation_select_q == `MODE_PROFILE_POS);

    // ********************************
    // Power state transitions
    // ********************************
    always @* begin
        state_d = state_q;
        // Fault or lost voltage or quick stop drops straight to disabled
        if (fault_active || !command_word_q[`CW_VOLTAGE] || !command_word_q[`CW_QUICK_STOP_N]) begin
            state_d = ST_DISABLED;
        end else if (!command_word_q[`CW_SWITCH_ON]) begin
            state_d = ST_READY;
        end else if (!command_word_q[`CW_OPERATION]) begin
            case (state_q)
                ST_READY: begin
                    state_d = ST_SWITCHED_ON;
                end
                ST_SWITCHED_ON: begin
                    state_d = ST_SWITCHED_ON;
                end
                ST_ENABLED: begin
                    state_d = ST_SWITCHED_ON;
                end
                default: begin
                    state_d = state_q;
                end
            endcase
        end else begin
            case (state_q)
                ST_READY: begin
                    state_d = ST_SWITCHED_ON;
                end
                ST_SWITCHED_ON: begin
                    state_d = ST_ENABLED;
                end
                ST_ENABLED: begin
                    state_d = ST_ENABLED;
                end
                default: begin
                    state_d = state_q;
                end
            endcase
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            state_q <= ST_DISABLED;
        end else if (ce) begin
            state_q <= state_d;
        end
    end

    // ********************************
    // Trigger detection and planning
    // ********************************
    assign trigger_edge = command_word_q[`CW_NEW_SETPOINT] & ~trigger_prev_q;
    assign accept = trigger_edge & op_enabled & pp_selected;
    // A queued segment starts the cycle its predecessor lands
    assign start_pend = run_done & pend_q;
    assign busy_eff = run_busy | start_pend;
    assign accept_now = accept & (~busy_eff | command_word_q[`CW_IMMEDIATE]);
    assign halt = ~op_enabled;

    // End of the running segment is the base for relative moves, so an
    // immediate replan keeps the travel not yet executed.
    always @* begin
        load = 1'b0;
        load_end = goal_position_q;
        rel_sum = {1'b0, run_end} + {1'b0, (accept_now ? goal_position_q : pend_goal_q)};
        if (accept_now) begin
            load = 1'b1;
            if (command_word_q[`CW_RELATIVE]) begin
                load_end = rel_sum[31:0];
            end
        end else if (start_pend) begin
            load = 1'b1;
            if (pend_rel_q) begin
                load_end = rel_sum[31:0];
            end else begin
                load_end = pend_goal_q;
            end
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            trigger_prev_q <= 1'b0;
            pend_q <= 1'b0;
            pend_rel_q <= 1'b0;
            pend_goal_q <= `RST_WORD32;
        end else if (ce) begin
            trigger_prev_q <= command_word_q[`CW_NEW_SETPOINT];
            if (halt) begin
                pend_q <= 1'b0;
            end else if (accept && busy_eff && !command_word_q[`CW_IMMEDIATE]) begin
                pend_q <= 1'b1;
                pend_rel_q <= command_word_q[`CW_RELATIVE];
                pend_goal_q <= goal_position_q;
            end else if (accept_now || start_pend) begin
                pend_q <= 1'b0;
            end
        end
    end

    // Set wins over clear: a trigger landing with a completion keeps ack high
    always @(posedge clk) begin
        if (srst) begin
            reached_q <= 1'b1;
            ack_q <= 1'b0;
        end else if (ce) begin
            if (accept) begin
                reached_q <= 1'b0;
                ack_q <= 1'b1;
            end else if (halt) begin
                ack_q <= 1'b0;
            end else if (run_done && !pend_q) begin
                reached_q <= 1'b1;
                ack_q <= 1'b0;
            end
        end
    end

    segment_runner u_runner (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .load(load),
        .load_end(load_end),
        .halt(halt),
        .max_speed(move_velocity_q),
        .accel(move_accel_q),
        .decel(move_decel_q),
        .pos_q(run_pos),
        .end_q(run_end),
        .speed_q(run_speed),
        .busy_q(run_busy),
        .done_q(run_done)
    );

    // ********************************
    // State word
    // ********************************
    assign state_word[`SW_READY] = ~state_q[0];
    assign state_word[`SW_SWITCHED_ON] = state_q[2] | state_q[3];
    assign state_word[`SW_OP_ENABLED] = state_q[3];
    assign state_word[`SW_FAULT] = fault_active;
    assign state_word[`SW_VOLTAGE] = state_q[2] | state_q[3];
    assign state_word[`SW_QUICK_STOP_N] = ~state_q[0];
    assign state_word[`SW_ON_DISABLED] = state_q[0];
    assign state_word[8:7] = 2'b00;
    assign state_word[`SW_REMOTE] = 1'b1;
    assign state_word[`SW_TARGET_REACHED] = reached_q & ~state_q[0];
    assign state_word[11] = 1'b0;
    assign state_word[`SW_SETPOINT_ACK] = ack_q;
    assign state_word[`SW_FOLLOW_ERR] = following_error;
    assign state_word[14] = 1'b0;
    assign state_word[`SW_HOME_FOUND] = home_done;

    assign demand_position = run_pos;
    assign demand_speed = run_speed;
    assign motion_busy = run_busy;
    assign drive_enabled = op_enabled;

    // ********************************
    // Object dictionary access
    // ********************************
    // A write to a read-only or unknown index is refused with od_err and
    // leaves every entry unchanged.
    always @(posedge clk) begin
        if (srst) begin
            command_word_q <= `RST_COMMAND_WORD;
            operation_select_q <= `RST_OP_SELECT;
            goal_position_q <= `RST_WORD32;
            move_velocity_q <= `RST_WORD32;
            move_accel_q <= `RST_WORD32;
            move_decel_q <= `RST_WORD32;
        end else if (ce && od_wr) begin
            case (od_index)
                `OD_COMMAND_WORD: begin
                    command_word_q <= od_wdata[15:0];
                end
                `OD_OP_SELECT: begin
                    operation_select_q <= od_wdata[7:0];
                end
                `OD_GOAL_POS: begin
                    goal_position_q <= od_wdata;
                end
                `OD_MOVE_VEL: begin
                    move_velocity_q <= od_wdata;
                end
                `OD_MOVE_ACCEL: begin
                    move_accel_q <= od_wdata;
                end
                `OD_MOVE_DECEL: begin
                    move_decel_q <= od_wdata;
                end
                default: begin
                    command_word_q <= command_word_q;
                end
            endcase
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            od_rdata <= `RST_WORD32;
            od_ack <= 1'b0;
            od_err <= 1'b0;
        end else if (ce) begin
            od_ack <= od_wr | od_rd;
            od_err <= 1'b0;
            if (od_wr) begin
                case (od_index)
                    `OD_COMMAND_WORD, `OD_OP_SELECT, `OD_GOAL_POS,
                    `OD_MOVE_VEL, `OD_MOVE_ACCEL, `OD_MOVE_DECEL: begin
                        od_err <= 1'b0;
                    end
                    default: begin
                        od_err <= 1'b1;
                    end
                endcase
            end else if (od_rd) begin
                case (od_index)
                    `OD_FAULT_CODE: begin
                        od_rdata <= {16'h0000, fault_code_in};
                    end
                    `OD_COMMAND_WORD: begin
                        od_rdata <= {16'h0000, command_word_q};
                    end
                    `OD_STATE_WORD: begin
                        od_rdata <= {16'h0000, state_word};
                    end
                    `OD_OP_SELECT: begin
                        od_rdata <= {24'h00_0000, operation_select_q};
                    end
                    `OD_OP_IN_EFFECT: begin
                        od_rdata <= {24'h00_0000, operation_select_q};
                    end
                    `OD_POS_DEMAND: begin
                        od_rdata <= run_pos;
                    end
                    `OD_POS_ENCODER: begin
                        od_rdata <= enc_position;
                    end
                    `OD_POS_USER: begin
                        od_rdata <= user_position;
                    end
                    `OD_VEL_ACTUAL: begin
                        od_rdata <= actual_velocity;
                    end
                    `OD_GOAL_POS: begin
                        od_rdata <= goal_position_q;
                    end
                    `OD_MOVE_VEL: begin
                        od_rdata <= move_velocity_q;
                    end
                    `OD_MOVE_ACCEL: begin
                        od_rdata <= move_accel_q;
                    end
                    `OD_MOVE_DECEL: begin
                        od_rdata <= move_decel_q;
                    end
                    default: begin
                        od_rdata <= `RST_WORD32;
                        od_err <= 1'b1;
                    end
                endcase
            end
        end
    end

endmodule // profile_position_setpoint_handler

// File: tb/pp_handler_chk.sv
`timescale 1ns/100ps
`include "pp_setpoint_map.vh"
module pp_handler_chk (
    input wire clk,
    input wire srst,
    input wire ce,
    input wire [15:0] od_index,
    input wire od_wr,
    input wire od_rd,
    input wire [31:0] od_rdata,
    input wire od_ack,
    input wire od_err,
    input wire following_error,
    input wire motion_busy,
    input wire drive_enabled
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (srst);
    // ****
    // Register port and state word
    // ****
    sequence s_req;
        ce && (od_wr || od_rd);
    endsequence
    // State word read whose source register was loaded outside reset
    sequence s_sw_rd;
        ce && od_rd && !od_wr && od_index == `OD_STATE_WORD && !$past(srst);
    endsequence
    chk_ack_follow: assert property (s_req |=> od_ack)
        else $error("access not answered");
    chk_ack_alone: assert property (ce && !(od_wr || od_rd) |=> !od_ack)
        else $error("answer without access");
    chk_ro_refused: assert property (
        ce && od_wr && od_index == `OD_STATE_WORD |=> od_ack && od_err)
        else $error("read-only write accepted");
    chk_err_paired: assert property (od_err |-> od_ack)
        else $error("error without answer");
    chk_upper_zero: assert property (s_sw_rd |=> od_rdata[31:16] == 16'h0000)
        else $error("state word upper half set");
    chk_follow_bit: assert property (
        s_sw_rd ##0 $stable(following_error) |=> od_rdata[13] == $past(following_error))
        else $error("deviation flag wrong");
    chk_busy_flags: assert property (
        s_sw_rd ##0 motion_busy && $past(motion_busy) |=> od_rdata[12] && !od_rdata[10])
        else $error("flags wrong while moving");
    chk_enable_bit: assert property (s_sw_rd ##0 drive_enabled |=> od_rdata[2])
        else $error("enabled flag missing");
endmodule // pp_handler_chk
bind profile_position_setpoint_handler pp_handler_chk i_pp_handler_chk (.clk(clk), .srst(srst), .ce(ce),
    .od_index(od_index), .od_wr(od_wr), .od_rd(od_rd), .od_rdata(od_rdata), .od_ack(od_ack), .od_err(od_err),
    .following_error(following_error), .motion_busy(motion_busy), .drive_enabled(drive_enabled));

// File: tb/fieldbus_master_model.sv
`timescale 1ns/100ps
module fieldbus_master_model (
    input wire clk,
    output logic [15:0] od_index,
    output logic od_wr,
    output logic od_rd,
    output logic [31:0] od_wdata,
    input wire [31:0] od_rdata,
    input wire od_ack,
    input wire od_err
);
    initial begin
        od_index = 16'h0000;
        od_wr = 1'b0;
        od_rd = 1'b0;
        od_wdata = 32'h0;
    end
    // Strobe lasts one cycle; the answer is settled at the falling edge after the taking edge
    task access(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] q,
                output logic e, output logic ok);
        int n;
        ok = 1'b0;
        @(negedge clk);
        od_index = a;
        od_wdata = d;
        od_wr = w;
        od_rd = !w;
        for (n = 0; n < 4 && !ok; n++) begin
            @(negedge clk);
            od_wr = 1'b0;
            od_rd = 1'b0;
            ok = (od_ack === 1'b1);
        end
        q = od_rdata;
        e = od_err;
        // Released lines must not keep looking valid
        od_wdata = ~d;
        od_index = ~a;
    endtask
endmodule // fieldbus_master_model

// File: tb/profile_position_setpoint_handler_test.sv
`timescale 1ns/100ps
`include "pp_setpoint_map.vh"
module profile_position_setpoint_handler_test;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic fe = 1'b0;
    logic hd = 1'b0;
    logic [15:0] fcode = 16'h0000;
    logic [31:0] enc = 32'h0;
    logic [31:0] upos = 32'h0;
    logic [31:0] avel = 32'h0;
    logic [31:0] rnd = 32'h0000_e17d;
    wire [15:0] idx;
    wire wr, rd, ack, err, busy;
    wire [31:0] wdata, rdata, dpos, dspd;
    int bad_count = 0;
    int checks = 0;
    // Model: power state, flags and queue of segment end points
    logic [15:0] m_pw = 16'h0240;
    logic [31:0] m_end = 32'h0;
    logic [31:0] m_q[$];
    logic m_ack = 1'b0;
    logic m_reach = 1'b1;
    logic [7:0] m_mode = 8'h00;
    always #2 clk = ~clk;
    fieldbus_master_model i_fieldbus_master (.clk(clk), .od_index(idx), .od_wr(wr), .od_rd(rd), .od_wdata(wdata),
        .od_rdata(rdata), .od_ack(ack), .od_err(err));
    profile_position_setpoint_handler i_profile_position_setpoint_handler (.clk(clk), .srst(srst), .ce(ce),
        .od_index(idx), .od_wr(wr), .od_rd(rd), .od_wdata(wdata), .od_rdata(rdata), .od_ack(ack), .od_err(err),
        .fault_code_in(fcode), .fault_active(1'b0), .following_error(fe), .home_done(hd), .enc_position(enc),
        .user_position(upos), .actual_velocity(avel), .demand_position(dpos), .demand_speed(dspd),
        .motion_busy(busy), .drive_enabled());
    function automatic logic [31:0] xs();
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
        return rnd;
    endfunction
    function automatic logic [31:0] exp_sw();
        logic [15:0] b;
        b = (m_pw == 16'h0637) ? {3'b000, m_ack, 1'b0, m_reach, 10'h237} : m_pw;
        return {16'h0000, hd, 1'b0, fe, b[12:0]};
    endfunction
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task complete_run();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task note(input string s);
        $display("test %s finished at %0t", s, $time);
    endtask
    task acc(input logic w, input logic [15:0] a, input logic [31:0] d, input logic xe, output logic [31:0] q);
        logic e;
        logic ok;
        i_fieldbus_master.access(w, a, d, q, e, ok);
        if (ok !== 1'b1) begin
            bad_count++;
            complete_run();
        end
        cmp({31'h0, e}, {31'h0, xe});
    endtask
    task chk_sw();
        logic [31:0] q;
        acc(1'b0, `OD_STATE_WORD, 32'h0, 1'b0, q);
        cmp(q, exp_sw());
    endtask
    task trig(input logic imm, input logic rel, input logic [31:0] g);
        logic [31:0] b;
        if (m_mode != 8'h01 || m_pw != 16'h0637)
            return;
        b = (m_q.size() != 0) ? m_q[0] : m_end;
        if (imm)
            m_q.delete();
        while (m_q.size() > 1)
            void'(m_q.pop_back());
        m_q.push_back(rel ? b + g : g);
        m_ack = 1'b1;
        m_reach = 1'b0;
    endtask
    task move(input logic imm, input logic rel);
        logic [31:0] q;
        logic [31:0] g;
        logic [15:0] cw;
        g = 32'h78 + (xs() & 32'h3f);
        if (!rel)
            g = g + ((m_q.size() != 0) ? m_q[$] : m_end);
        cw = {9'h000, rel, imm, 5'h0f};
        acc(1'b1, `OD_GOAL_POS, g, 1'b0, q);
        acc(1'b1, `OD_COMMAND_WORD, {16'h0000, cw}, 1'b0, q);
        acc(1'b1, `OD_COMMAND_WORD, {16'h0000, cw | 16'h0010}, 1'b0, q);
        trig(imm, rel, g);
        chk_sw();
    endtask
    // Chained segments may show short gaps in busy, so idle must last several cycles
    task wait_done();
        int n;
        int quiet;
        quiet = 0;
        for (n = 0; n < 3000 && quiet < 4; n++) begin
            @(negedge clk);
            quiet = (busy === 1'b0) ? quiet + 1 : 0;
        end
        if (quiet < 4) begin
            bad_count++;
            complete_run();
        end
        m_end = m_q[$];
        m_q.delete();
        m_ack = 1'b0;
        m_reach = 1'b1;
    endtask
    initial begin
        logic [31:0] q;
        logic [31:0] r;
        logic [15:0] rw_idx[5] = '{`OD_GOAL_POS, `OD_MOVE_VEL, `OD_MOVE_ACCEL, `OD_MOVE_DECEL, `OD_OP_SELECT};
        logic [15:0] ro_idx[5] = '{`OD_FAULT_CODE, `OD_POS_ENCODER, `OD_POS_USER, `OD_VEL_ACTUAL, `OD_POS_DEMAND};
        logic [31:0] ro_exp[5];
        logic [15:0] pw[3] = '{16'h0006, 16'h0007, 16'h000f};
        logic [15:0] sw[3] = '{16'h0621, 16'h0633, 16'h0637};
        r = xs();
        fcode = r[15:0];
        enc = xs();
        upos = xs();
        avel = xs();
        repeat (2) @(negedge clk);
        srst = 1'b0;
        chk_sw();
        foreach (rw_idx[i]) begin
            r = xs();
            acc(1'b0, rw_idx[i], 32'h0, 1'b0, q);
            cmp(q, 32'h0);
            acc(1'b1, rw_idx[i], r, 1'b0, q);
            acc(1'b0, rw_idx[i], 32'h0, 1'b0, q);
            cmp(q, (i == 4) ? {24'h00_0000, r[7:0]} : r);
        end
        acc(1'b1, `OD_STATE_WORD, xs(), 1'b1, q);
        acc(1'b0, 16'h6000, 32'h0, 1'b1, q);
        cmp(q, 32'h0);
        chk_sw();
        note("registers");
        foreach (pw[i]) begin
            acc(1'b1, `OD_COMMAND_WORD, {16'h0000, pw[i]}, 1'b0, q);
            m_pw = sw[i];
            chk_sw();
        end
        acc(1'b1, `OD_OP_SELECT, 32'h1, 1'b0, q);
        acc(1'b1, `OD_MOVE_VEL, 32'h3, 1'b0, q);
        acc(1'b1, `OD_MOVE_ACCEL, 32'h1, 1'b0, q);
        acc(1'b1, `OD_MOVE_DECEL, 32'h1, 1'b0, q);
        acc(1'b0, `OD_OP_IN_EFFECT, 32'h0, 1'b0, q);
        cmp(q, 32'h1);
        m_mode = 8'h01;
        note("enable");
        for (int k = 0; k < 4; k++) begin
            move(1'b0, k[1]);
            move(k[0], k[1]);
            // Clock enable low must freeze a running segment
            if (k == 3) begin
                r = dpos;
                ce = 1'b0;
                repeat (6) @(negedge clk);
                cmp(dpos, r);
                ce = 1'b1;
            end
            wait_done();
            cmp(dpos, m_end);
            cmp(dspd, 32'h0);
            chk_sw();
        end
        note("moves");
        ro_exp = '{{16'h0000, fcode}, enc, upos, avel, m_end};
        foreach (ro_idx[i]) begin
            acc(1'b0, ro_idx[i], 32'h0, 1'b0, q);
            cmp(q, ro_exp[i]);
        end
        acc(1'b1, `OD_OP_SELECT, 32'h0, 1'b0, q);
        m_mode = 8'h00;
        move(1'b0, 1'b1);
        for (int k = 0; k < 4; k++) begin
            fe = k[0];
            hd = k[1];
            chk_sw();
        end
        acc(1'b1, `OD_COMMAND_WORD, 32'h0000_000b, 1'b0, q);
        m_pw = 16'h0240;
        chk_sw();
        note("flags");
        complete_run();
    end
endmodule // profile_position_setpoint_handler_test
